// ===== hw/sram_cycle_ctrl.sv
// What this block does
// - Burst steps only two low address bits.
// - Load low ends burst, takes new address.
// - Direction ignored on every burst step.
// - Load-edge direction fixes whole burst.
// - Direction low writes, high reads.
// - Strobes captured one cycle before data.
// - Suspended edge ignores all synchronous inputs.
// - Suspended edge holds every internal register.
// - Inactive select on a load edge deselects, bus floats next; select is ignored on burst steps.
// - Write data accepted cycle after load.
// - Read data driven cycle after load.
`timescale 1ns/1ps
`default_nettype none

`include "sram_ctrl_defines.svh"

module sram_cycle_ctrl #(
  parameter int ADDR_W = `DEF_ADDR_W,
  parameter int DATA_W = `DEF_DATA_W,
  parameter int LANES  = `DEF_LANES
) (
  // Clock and reset
  input  wire  logic                clock_i,
  input  wire  logic                rst_n_i,
  // Address and control
  input  wire  logic [ADDR_W-1:0]   addr_i,
  input  wire  logic                write_read_i,
  input  wire  logic                advance_or_load_i,
  input  wire  logic                burst_order_select_i,
  input  wire  logic                clock_suspend_n_i,
  // Chip selects
  input  wire  logic                chip_select_first_n_i,
  input  wire  logic                chip_select_second_n_i,
  input  wire  logic                chip_select_high_i,
  // Write strobes and data bus
  input  wire  logic [LANES-1:0]    byte_lane_write_strobe_n_i,
  input  wire  logic [DATA_W-1:0]   data_i,
  output logic       [DATA_W-1:0]   data_o,
  output logic                      data_oe_o,
  // Status
  output logic                      burst_active_o,
  output logic                      burst_write_o,
  output logic       [ADDR_W-1:0]   cur_addr_o
);

  localparam int LANE_W = DATA_W / LANES;
  // The word array is one entry per address, held in flip-flops.
  localparam int DEPTH  = 1 << ADDR_W;

  // ============================================================
  // State
  // The word array lives in the state, so a suspended edge holds it too.
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic                         active;
    sram_ctrl_pkg::op_dir_e       dir;
    logic                         wr_burst;
    logic [ADDR_W-1:0]            base;
    logic [`BURST_CNT_W-1:0]      count;
    logic                         order;
    logic [ADDR_W-1:0]            cur_addr;
    logic                         wr_pend;
    logic [ADDR_W-1:0]            wr_addr;
    logic [LANES-1:0]             wr_lanes;
    logic [DATA_W-1:0]            rd_data;
    logic                         oe;
  } state_s;

  state_s q;
  state_s d;

  // ============================================================
  // Helpers
  // All three selects must be active; any one inactive deselects.
  function automatic logic selected(input logic first_n, input logic second_n,
                                    input logic high);
    selected = !first_n && !second_n && high;
  endfunction

  // Direction decode, shared by the op path and the status flag.
  function automatic logic is_write(input sram_ctrl_pkg::op_dir_e dir);
    is_write = (dir == sram_ctrl_pkg::DIR_WRITE);
  endfunction

  function automatic sram_ctrl_pkg::op_dir_e dir_of(input logic write_read);
    if (write_read == `DIR_READ_LVL) begin
      dir_of = sram_ctrl_pkg::DIR_READ;
    end else begin
      dir_of = sram_ctrl_pkg::DIR_WRITE;
    end
  endfunction

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_word,
                                                   input logic [DATA_W-1:0] new_word,
                                                   input logic [LANES-1:0]  lanes);
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    lane_merge = res;
  endfunction

  // ============================================================
  // Burst address sequencing
  burst_seq_if seq ();

  burst_addr_gen u_gen (
    .seq (seq.gen)
  );

  logic [`BURST_CNT_W-1:0] next_count;
  logic [ADDR_W-1:0]       step_addr;
  logic                    run_edge;

  // The count wraps, so advancing past the fourth word revisits the first.
  assign next_count     = sram_ctrl_pkg::burst_low_t'(q.count + `BURST_CNT_STEP);
  assign seq.base_low   = q.base[`BURST_LOW_MSB:0];
  assign seq.count      = next_count;
  assign seq.interleave = q.order;

  // Upper address bits stay at the loaded base for the whole burst.
  assign step_addr      = {q.base[ADDR_W-1:`BURST_HIGH_LSB], seq.addr_low};
  // A suspended edge leaves every register as it was.
  assign run_edge       = (clock_suspend_n_i != `SUSPEND_LVL);

  // ============================================================
  // Next state
  always_comb begin
    logic                   do_op;
    logic [ADDR_W-1:0]      op_addr;
    sram_ctrl_pkg::op_dir_e op_dir;
    do_op   = 1'b0;
    op_addr = q.cur_addr;
    op_dir  = q.dir;
    d       = q;
    if (run_edge) begin
      // pending write still completes
      // The merge lands before any read below, so a read right after a
      // write to the same word sees the new data.
      if (q.wr_pend) begin
        d.mem[q.wr_addr] = lane_merge(q.mem[q.wr_addr], data_i, q.wr_lanes);
      end
      d.wr_pend = 1'b0;
      d.oe      = 1'b0;
      if (advance_or_load_i == `LOAD_LVL) begin
        if (selected(chip_select_first_n_i, chip_select_second_n_i, chip_select_high_i)) begin
          d.active = 1'b1;
          d.dir    = dir_of(write_read_i);
          d.base   = addr_i;
          d.count  = `BURST_CNT_START;
          d.order  = burst_order_select_i;
          do_op    = 1'b1;
          op_addr  = addr_i;
          op_dir   = d.dir;
        end else begin
          // Deselect ends the burst; a pending write has still landed above.
          d.active = 1'b0;
        end
      end else if (q.active) begin
        d.count = next_count;
        do_op   = 1'b1;
        op_addr = step_addr;
        op_dir  = q.dir;
      end
      // Status flag follows the burst that this edge leaves running.
      d.wr_burst = d.active && is_write(d.dir);
      if (do_op) begin
        d.cur_addr = op_addr;
        if (is_write(op_dir)) begin
          // strobes lead data by one cycle
          d.wr_pend  = 1'b1;
          d.wr_addr  = op_addr;
          d.wr_lanes = ~byte_lane_write_strobe_n_i;
        end else begin
          // read data in next cycle
          // The word is shown straight from this register, with no extra stage.
          d.rd_data = d.mem[op_addr];
          d.oe      = 1'b1;
        end
      end
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Reset clears the word array along with the control state.
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Outputs
  assign data_o         = q.rd_data;
  // The bus drive enable is set by a read op and cleared by any other unsuspended edge.
  assign data_oe_o      = q.oe;
  assign burst_active_o = q.active;
  assign burst_write_o  = q.wr_burst;
  assign cur_addr_o     = q.cur_addr;

endmodule

`default_nettype wire

// ===== include/sram_ctrl_defines.svh
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH

// ============================================================
// Burst counter
`define BURST_CNT_W     2
`define BURST_CNT_START 2'h0
`define BURST_CNT_STEP  2'h1
`define BURST_LOW_MSB   1
`define BURST_HIGH_LSB  2

// ============================================================
// Pin encodings
`define DIR_READ_LVL    1'b1
`define ORDER_INTERLEAVE 1'b1
`define LOAD_LVL        1'b0
`define SUSPEND_LVL     1'b1

// ============================================================
// Default geometry and reset values
`define DEF_ADDR_W      8
`define DEF_DATA_W      36
`define DEF_LANES       4
`define RST_BIT         1'b0

`endif

// ===== include/sram_ctrl_pkg.sv
// ============================================================
// Shared types
package sram_ctrl_pkg;

  typedef enum logic {
    DIR_WRITE,
    DIR_READ
  } op_dir_e;

  typedef logic [1:0] burst_low_t;

endpackage

// ===== include/burst_seq_if.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Burst sequence request and answer
interface burst_seq_if;
  sram_ctrl_pkg::burst_low_t base_low;
  sram_ctrl_pkg::burst_low_t count;
  logic                      interleave;
  sram_ctrl_pkg::burst_low_t addr_low;

  modport gen (
    input  base_low,
    input  count,
    input  interleave,
    output addr_low
  );

  modport user (
    output base_low,
    output count,
    output interleave,
    input  addr_low
  );
endinterface

`default_nettype wire

// ===== hw/burst_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none

`include "sram_ctrl_defines.svh"

// ============================================================
// Low address bits for one burst step
module burst_addr_gen (
  // Sequence port
  burst_seq_if.gen seq
);

  always_comb begin
    if (seq.interleave == `ORDER_INTERLEAVE) begin
      seq.addr_low = seq.base_low ^ seq.count;
    end else begin
      seq.addr_low = sram_ctrl_pkg::burst_low_t'(seq.base_low + seq.count);
    end
  end

endmodule

`default_nettype wire

// ===== bench/sram_cycle_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_ctrl_props #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 36
) (
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              write_read_i,
  input wire logic              advance_or_load_i,
  input wire logic              burst_order_select_i,
  input wire logic              clock_suspend_n_i,
  input wire logic              chip_select_first_n_i,
  input wire logic              chip_select_second_n_i,
  input wire logic              chip_select_high_i,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              data_oe_o,
  input wire logic              burst_active_o,
  input wire logic              burst_write_o,
  input wire logic [ADDR_W-1:0] cur_addr_o
);
  logic sel, ld, adv, ord_q;
  assign sel = !chip_select_first_n_i && !chip_select_second_n_i && chip_select_high_i;
  assign ld = !clock_suspend_n_i && !advance_or_load_i;
  assign adv = !clock_suspend_n_i && advance_or_load_i && burst_active_o;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) ord_q <= 1'b0;
    else if (ld) ord_q <= burst_order_select_i;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd; ld && sel && write_read_i |=> data_oe_o && !burst_write_o; endproperty
  a_rd: assert property (p_rd) else $error("read load not driven");
  property p_wr; ld && sel && !write_read_i |=> !data_oe_o && burst_write_o; endproperty
  a_wr: assert property (p_wr) else $error("write load wrong");
  property p_ds; ld && !sel |=> !data_oe_o && !burst_active_o; endproperty
  a_ds: assert property (p_ds) else $error("deselect wrong");
  property p_ld; ld && sel |=> burst_active_o && cur_addr_o == $past(addr_i); endproperty
  a_ld: assert property (p_ld) else $error("load address wrong");
  property p_hold;
    clock_suspend_n_i |=> $stable(cur_addr_o) && $stable(data_o) && $stable(data_oe_o);
  endproperty
  a_hold: assert property (p_hold) else $error("suspended edge changed state");
  property p_hi; adv |=> cur_addr_o[ADDR_W-1:2] == $past(cur_addr_o[ADDR_W-1:2]); endproperty
  a_hi: assert property (p_hi) else $error("upper address moved");
  property p_dir; adv |=> burst_write_o == $past(burst_write_o) && data_oe_o != burst_write_o;
  endproperty
  a_dir: assert property (p_dir) else $error("burst direction changed");
  property p_lin; adv && !ord_q |=> cur_addr_o[1:0] == $past(cur_addr_o[1:0]) + 2'h1; endproperty
  a_lin: assert property (p_lin) else $error("linear step wrong");
  c_rd: cover property (ld && sel && write_read_i);
  c_adv: cover property (adv && burst_write_o);
  c_sus: cover property (clock_suspend_n_i && burst_active_o);
endmodule
bind sram_cycle_ctrl sram_cycle_ctrl_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .clock_i, .rst_n_i, .addr_i, .write_read_i, .advance_or_load_i, .burst_order_select_i,
  .clock_suspend_n_i, .chip_select_first_n_i, .chip_select_second_n_i, .chip_select_high_i,
  .data_o, .data_oe_o, .burst_active_o, .burst_write_o, .cur_addr_o);
`default_nettype wire

// ===== bench/sram_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
  input  wire logic        clock_i,
  input  wire logic        hold_i,
  input  wire logic        cs_n_i,
  input  wire logic        wstep_i,
  input  wire logic [35:0] wdata_i,
  output logic             sel_n_o,
  output logic             sel_o,
  output logic      [35:0] data_o
);
  logic        pend_q = 1'b0;
  logic [35:0] word_q = 36'h0;
  logic [35:0] last_q = 36'h0;
  assign sel_n_o = cs_n_i;
  assign sel_o = !cs_n_i;
  assign data_o = pend_q ? word_q : ~last_q;
  always @(posedge clock_i) begin
    if (!hold_i) begin
      last_q <= data_o;
      pend_q <= wstep_i;
      word_q <= wdata_i;
    end
  end
endmodule
`default_nettype wire

// ===== bench/sram_cycle_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_ctrl_bench;
  logic        clock_i = 0, rst_n_i = 0, write_read_i = 0, advance_or_load_i = 1;
  logic        burst_order_select_i = 0, clock_suspend_n_i = 0, cs_n = 0, wstep = 0;
  logic        chip_select_first_n_i, chip_select_second_n_i, chip_select_high_i;
  logic        data_oe_o, burst_active_o, burst_write_o, e_oe = 0, e_act = 0, e_wr = 0, e_o = 0;
  logic [1:0]  k = 0;
  logic [3:0]  byte_lane_write_strobe_n_i = 4'hf;
  logic [7:0]  addr_i = 0, cur_addr_o, base = 0, e_adr = 0;
  logic [35:0] data_i, data_o, wdata = 0, e_dat = 0, mem [256];
  int          bad_count = 0, tests_run = 0;
  assign chip_select_second_n_i = chip_select_first_n_i;
  always #20 clock_i = ~clock_i;
  sram_cycle_ctrl u_dut (.clock_i, .rst_n_i, .addr_i, .write_read_i, .advance_or_load_i,
    .burst_order_select_i, .clock_suspend_n_i, .chip_select_first_n_i, .chip_select_second_n_i,
    .chip_select_high_i, .byte_lane_write_strobe_n_i, .data_i, .data_o, .data_oe_o,
    .burst_active_o, .burst_write_o, .cur_addr_o);
  sram_host_model u_host (.clock_i, .hold_i(clock_suspend_n_i), .cs_n_i(cs_n), .wstep_i(wstep),
    .wdata_i(wdata), .sel_n_o(chip_select_first_n_i), .sel_o(chip_select_high_i), .data_o(data_i));
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] low(input logic [1:0] b, input logic [1:0] c, input logic o);
    return o ? b ^ c : b + c;
  endfunction
  task automatic cyc(input logic ld, rd, sel, su, o, input logic [7:0] a);
    logic op;
    @(negedge clock_i);
    chk({data_oe_o, burst_active_o, cur_addr_o}, {e_oe, e_act, e_adr});
    if (e_act) chk(burst_write_o, e_wr);
    if (e_oe) chk(data_o, e_dat);
    clock_suspend_n_i = su;
    advance_or_load_i = !ld;
    write_read_i = ld ? rd : 1'($urandom);
    burst_order_select_i = o;
    addr_i = a;
    cs_n = !sel;
    wdata = {$urandom, 4'($urandom)};
    byte_lane_write_strobe_n_i = 4'($urandom);
    if (su) return;
    op = ld ? sel : e_act;
    if (ld && sel) begin
      base = a;
      k = 0;
      e_o = o;
      e_wr = !rd;
    end else if (op) begin
      k = k + 2'h1;
    end
    if (op) e_adr = {base[7:2], low(base[1:0], k, e_o)};
    if (ld) e_act = sel;
    e_oe = op && !e_wr;
    wstep = op && e_wr;
    e_dat = mem[e_adr];
    for (int i = 0; i < 4; i++)
      if (wstep && !byte_lane_write_strobe_n_i[i]) mem[e_adr][9*i+:9] = wdata[9*i+:9];
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = '0;
    void'($urandom(73599));
    repeat (20) @(negedge clock_i);
    rst_n_i = 1;
    cyc(1, 0, 1, 0, 0, 8'hfe);
    repeat (5) cyc(0, 0, 1, 0, 0, 8'h00);
    cyc(1, 1, 1, 0, 1, 8'hfe);
    repeat (5) cyc(0, 0, 1, 0, 0, 8'h00);
    cyc(1, 0, 1, 0, 0, 8'h11);
    cyc(1, 1, 1, 0, 1, 8'h11);
    cyc(1, 1, 0, 0, 0, 8'h22);
    cyc(0, 0, 1, 1, 0, 8'h33);
    repeat (600) cyc($urandom % 3 == 0, 1'($urandom), $urandom % 6 != 0,
      $urandom % 4 == 0, 1'($urandom), 8'($urandom % 24));
    cyc(0, 0, 1, 0, 0, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
